// [core/jfs_link_status_regs.sv]
// register bank: comma select, link status flags, channel enable, interrupts
`timescale 1ns/1ps
`default_nettype none
module jfs_link_status_regs
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  // register port
  input  wire logic [11:0] regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [7:0]       regRdata_r,
  // live link state
  input  wire logic        linkUp,
  input  wire logic        syncReqN,
  input  wire logic        sysrefEvt,
  input  wire logic        sysrefPhaseShift,
  input  wire logic        serdesPllLock,
  input  wire logic        convPllLock,
  // frame byte stream
  input  wire logic        frameEnd,
  input  wire logic        substOk,
  input  wire logic [7:0]  txData,
  input  wire logic        txCtrl,
  output logic [7:0]       txDataOut_r,
  output logic             txCtrlOut_r,
  // control outputs
  output logic             serialLinkEnable,
  output logic [7:0]       channelPairEnable,
  output logic             irq
);
  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // true when an access hits the given address
  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    hit = (a == target);
  endfunction

  logic wrComma;  // write to comma select
  logic wrStatus; // write to status flags
  logic wrChan;   // write to channel enable
  logic wrMask;   // write to interrupt mask
  logic wrCtrl;   // write to link control
  assign wrComma  = regWr & hit(regAddr, jfs_pkg::ADDR_COMMA_SEL);
  assign wrStatus = regWr & hit(regAddr, jfs_pkg::ADDR_STATUS);
  assign wrChan   = regWr & hit(regAddr, jfs_pkg::ADDR_CHAN_EN);
  assign wrMask   = regWr & hit(regAddr, jfs_pkg::ADDR_IRQ_MASK);
  assign wrCtrl   = regWr & hit(regAddr, jfs_pkg::ADDR_LINK_CTRL);

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [7:0] commaSel_r; // frame_end_comma_select
  logic [7:0] chanEn_r;   // channel_pair_enable
  logic [7:0] irqMask_r;  // interrupt mask, status layout
  logic [7:0] linkCtrl_r; // link enable and coding mode

  // plain storage; reserved bits masked so they read zero, except the interrupt mask, which stores the whole byte
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      commaSel_r <= jfs_pkg::RST_COMMA_SEL;
      chanEn_r   <= jfs_pkg::RST_CHAN_EN;
      irqMask_r  <= jfs_pkg::RST_ZERO;
      linkCtrl_r <= jfs_pkg::RST_ZERO;
    end
    else if (clkEn)
    begin
      // field held whole; change while enabled is not guarded in hardware
      if (wrComma)
        commaSel_r <= regWdata & jfs_pkg::COMMA_SEL_MASK;
      if (wrChan)
        chanEn_r <= regWdata & jfs_pkg::CHAN_EN_MASK;
      if (wrMask)
        irqMask_r <= regWdata;
      if (wrCtrl)
        linkCtrl_r <= regWdata & jfs_pkg::LINK_CTRL_MASK;
    end
  end

  logic mode8b10b; // link coded 8B/10B
  assign serialLinkEnable  = linkCtrl_r[jfs_pkg::BIT_LINK_EN];
  assign mode8b10b         = linkCtrl_r[jfs_pkg::BIT_CODE_8B10B];
  assign channelPairEnable = chanEn_r;

  // ----------------------------------------------------------------
  // alignment event detection
  // ----------------------------------------------------------------
  logic linkEnPrev_r;   // link enable one cycle ago
  logic armFirst_r;     // waiting for first SYSREF after enable
  logic armFirst_nxt;
  logic firstSysref;    // first SYSREF after enable
  assign firstSysref  = armFirst_r & sysrefEvt & serialLinkEnable;
  assign armFirst_nxt = (serialLinkEnable & ~linkEnPrev_r) | (armFirst_r & ~firstSysref & serialLinkEnable);

  // tracks the enable edge to re-arm first SYSREF detection
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      linkEnPrev_r <= 1'b0;
      armFirst_r   <= 1'b0;
    end
    else if (clkEn)
    begin
      linkEnPrev_r <= serialLinkEnable;
      armFirst_r   <= armFirst_nxt;
    end
  end

  logic clrRealign; // write one clears realigned flag
  logic clrMfPhase; // write one clears phase set flag
  logic realignFlag;
  logic multiframePhaseSetFlag;
  assign clrRealign = wrStatus & regWdata[jfs_pkg::BIT_REALIGNED];
  assign clrMfPhase = wrStatus & regWdata[jfs_pkg::BIT_MF_PHASE];

  jfs_sticky_flag u_realign
  (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .setEvt  (sysrefEvt & sysrefPhaseShift),
    .clrReq  (clrRealign),
    .flag_r  (realignFlag)
  );

  jfs_sticky_flag u_mf_phase
  (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .setEvt  (firstSysref),
    .clrReq  (clrMfPhase),
    .flag_r  (multiframePhaseSetFlag)
  );

  // ----------------------------------------------------------------
  // status assembly
  // ----------------------------------------------------------------
  logic [7:0] statusWord; // live view of link_status_flags
  assign statusWord = {1'b0,
                       linkUp,
                       syncReqN,
                       realignFlag,
                       multiframePhaseSetFlag,
                       serdesPllLock,
                       1'b0,
                       convPllLock};

  // interrupt from sticky flags gated by mask
  assign irq = |(statusWord & irqMask_r & jfs_pkg::STICKY_MASK);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rdMux; // selected read data, zero when unmapped
  assign rdMux = hit(regAddr, jfs_pkg::ADDR_COMMA_SEL) ? commaSel_r :
                 hit(regAddr, jfs_pkg::ADDR_STATUS)    ? statusWord :
                 hit(regAddr, jfs_pkg::ADDR_CHAN_EN)   ? chanEn_r :
                 hit(regAddr, jfs_pkg::ADDR_IRQ_MASK)  ? irqMask_r :
                 hit(regAddr, jfs_pkg::ADDR_LINK_CTRL) ? linkCtrl_r :
                 jfs_pkg::RST_ZERO;

  // read data registered one cycle after strobe, zero otherwise
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      regRdata_r <= jfs_pkg::RST_ZERO;
    else if (clkEn)
      regRdata_r <= regRd ? rdMux : jfs_pkg::RST_ZERO;
  end

  // ----------------------------------------------------------------
  // frame character substitution
  // ----------------------------------------------------------------
  jfs_comma_inserter u_comma
  (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clkEn     (clkEn),
    .commaSel  (commaSel_r[jfs_pkg::COMMA_SEL_W-1:0]),
    .mode8b10b (mode8b10b),
    .frameEnd  (frameEnd),
    .substOk   (substOk),
    .dataIn    (txData),
    .ctrlIn    (txCtrl),
    .dataOut_r (txDataOut_r),
    .ctrlOut_r (txCtrlOut_r)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_link_up_read: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && regRd && hit(regAddr, jfs_pkg::ADDR_STATUS) |=> regRdata_r[jfs_pkg::BIT_LINK_UP] == $past(linkUp))
    else $error("link up bit wrong");
  a_sync_read: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && regRd && hit(regAddr, jfs_pkg::ADDR_STATUS) |=> regRdata_r[jfs_pkg::BIT_SYNC_STAT] == $past(syncReqN))
    else $error("sync status bit wrong");
  a_pll_reads: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && regRd && hit(regAddr, jfs_pkg::ADDR_STATUS) |=>
    regRdata_r[jfs_pkg::BIT_SPLL_LOCK] == $past(serdesPllLock) && regRdata_r[jfs_pkg::BIT_CPLL_LOCK] == $past(convPllLock))
    else $error("pll lock bits wrong");
  a_realign_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && realignFlag && !clrRealign |=> realignFlag)
    else $error("realigned flag dropped without clear");
  a_first_sysref: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && serialLinkEnable && !linkEnPrev_r ##1 clkEn && sysrefEvt && serialLinkEnable |=> multiframePhaseSetFlag)
    else $error("first sysref did not set phase flag");
  a_status_write_inert: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && wrStatus && !regWdata[jfs_pkg::BIT_MF_PHASE] && !firstSysref && multiframePhaseSetFlag
    |=> multiframePhaseSetFlag)
    else $error("status write without one altered flag");
  a_comma_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)
    commaSel_r[7:2] == 6'h00)
    else $error("comma select reserved bits nonzero");
  a_read_one_cycle: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && !regRd |=> regRdata_r == 8'h00)
    else $error("read data outside read slot");
  a_irq_level: assert property (@(posedge clock) disable iff (sys_rst)
    realignFlag && irqMask_r[jfs_pkg::BIT_REALIGNED] |-> irq)
    else $error("interrupt missing");

  // ----------------------------------------------------------------
  // register write checks
  // ----------------------------------------------------------------
  // comma write lands with the reserved bits cut to zero
  a_comma_write: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && wrComma |=> commaSel_r == ($past(regWdata) & jfs_pkg::COMMA_SEL_MASK))
    else $error("comma select write lost");
  // comma select keeps its value between writes
  a_comma_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !(clkEn && wrComma) |=> commaSel_r == $past(commaSel_r))
    else $error("comma select changed without write");
  // channel enable keeps only its defined bits
  a_chan_write: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && wrChan |=> chanEn_r == ($past(regWdata) & jfs_pkg::CHAN_EN_MASK))
    else $error("channel enable write lost");
  // interrupt mask stores the whole byte
  a_mask_write: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && wrMask |=> irqMask_r == $past(regWdata))
    else $error("interrupt mask write lost");
  // link control keeps enable and coding mode only
  a_ctrl_write: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && wrCtrl |=> linkCtrl_r == ($past(regWdata) & jfs_pkg::LINK_CTRL_MASK))
    else $error("link control write lost");
  // nothing moves while the clock enable is low
  a_freeze_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !clkEn |=> $stable(commaSel_r) && $stable(linkCtrl_r) && $stable(regRdata_r) &&
    $stable(realignFlag) && $stable(multiframePhaseSetFlag))
    else $error("state changed while clock enable low");

  // ----------------------------------------------------------------
  // flag and interrupt checks
  // ----------------------------------------------------------------
  // realigning sysref with clock enable high always sets the flag
  a_realign_set: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && sysrefEvt && sysrefPhaseShift |=> realignFlag)
    else $error("realigning sysref not flagged");
  // a written one clears the realigned flag when no event competes
  a_realign_clear: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && clrRealign && !(sysrefEvt && sysrefPhaseShift) |=> !realignFlag)
    else $error("realigned flag did not clear");
  // a written one clears the phase set flag when no event competes
  a_mf_clear: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && clrMfPhase && !firstSysref |=> !multiframePhaseSetFlag)
    else $error("phase set flag did not clear");
  // phase set flag cannot rise while the link is disabled
  a_mf_needs_enable: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && !serialLinkEnable && !multiframePhaseSetFlag |=> !multiframePhaseSetFlag)
    else $error("phase set flag rose with link disabled");
  // enable rising arms first sysref detection
  a_arm_on_enable: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && serialLinkEnable && !linkEnPrev_r |=> armFirst_r)
    else $error("enable edge did not arm detection");
  // a disabled link drops the arm
  a_disarm_off: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && !serialLinkEnable |=> !armFirst_r)
    else $error("detection armed with link disabled");
  // phase set flag raises the interrupt when enabled in the mask
  a_irq_mf: assert property (@(posedge clock) disable iff (sys_rst)
    multiframePhaseSetFlag && irqMask_r[jfs_pkg::BIT_MF_PHASE] |-> irq)
    else $error("phase set interrupt missing");
  // no enabled sticky bit means no interrupt
  a_irq_masked_off: assert property (@(posedge clock) disable iff (sys_rst)
    (irqMask_r & jfs_pkg::STICKY_MASK) == jfs_pkg::RST_ZERO |-> !irq)
    else $error("interrupt with all sticky bits masked");
  c_realign_clear: cover property (@(posedge clock) realignFlag ##1 clrRealign ##1 !realignFlag);
  c_first_align: cover property (@(posedge clock) firstSysref);
  c_irq_seen: cover property (@(posedge clock) irq);
endmodule
`default_nettype wire

// [pkg/jfs_pkg.sv]
// constants and types for the link frame character and status register block
`default_nettype none
package jfs_pkg;
  // register map (byte addresses)
  localparam logic [11:0] ADDR_COMMA_SEL  = 12'h207; // frame_end_comma_select
  localparam logic [11:0] ADDR_STATUS     = 12'h208; // link_status_flags
  localparam logic [11:0] ADDR_CHAN_EN    = 12'h209; // channel_pair_enable
  localparam logic [11:0] ADDR_IRQ_MASK   = 12'h20C; // interrupt mask
  localparam logic [11:0] ADDR_LINK_CTRL  = 12'h20D; // serial_link_enable and coding mode
  // reset values
  localparam logic [7:0]  RST_COMMA_SEL   = 8'h00;
  localparam logic [7:0]  RST_CHAN_EN     = 8'h03;
  localparam logic [7:0]  RST_ZERO        = 8'h00;
  // status bit positions
  localparam int          BIT_LINK_UP     = 6;
  localparam int          BIT_SYNC_STAT   = 5;
  localparam int          BIT_REALIGNED   = 4;
  localparam int          BIT_MF_PHASE    = 3;
  localparam int          BIT_SPLL_LOCK   = 2;
  localparam int          BIT_CPLL_LOCK   = 0;
  // link control bit positions
  localparam int          BIT_LINK_EN     = 0;
  localparam int          BIT_CODE_8B10B  = 1;
  // comma select field
  localparam int          COMMA_SEL_W     = 2;
  localparam logic [7:0]  COMMA_SEL_MASK  = 8'h03;
  localparam logic [7:0]  CHAN_EN_MASK    = 8'h07;
  localparam logic [7:0]  LINK_CTRL_MASK  = 8'h03;
  localparam logic [7:0]  STICKY_MASK     = 8'h18;
  // 8B/10B control characters (data byte value with K flag)
  localparam logic [7:0]  K28_7           = 8'hFC;
  localparam logic [7:0]  K28_1           = 8'h3C;
  localparam logic [7:0]  K28_5           = 8'hBC;
  // comma select codes
  typedef enum logic [1:0]
  {
    COMMA_K28_7 = 2'b00,
    COMMA_K28_1 = 2'b01,
    COMMA_K28_5 = 2'b10,
    COMMA_RSVD  = 2'b11
  } jfs_comma_t;
endpackage
`default_nettype wire

// [core/jfs_sticky_flag.sv]
// one sticky flag: hardware set wins over write-one clear
`timescale 1ns/1ps
`default_nettype none
module jfs_sticky_flag
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic clkEn,
  input  wire logic setEvt,
  input  wire logic clrReq,
  output logic      flag_r
);
  // ----------------------------------------------------------------
  // flag storage
  // ----------------------------------------------------------------
  logic flag_nxt; // next value, set beats clear
  assign flag_nxt = setEvt | (flag_r & ~clrReq);

  // clocked update, frozen while clock enable low
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      flag_r <= 1'b0;
    else if (clkEn)
      flag_r <= flag_nxt;
  end

  a_set_wins: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && setEvt |=> flag_r)
    else $error("sticky flag lost a set");
  a_clear_works: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && clrReq && !setEvt |=> !flag_r)
    else $error("sticky flag did not clear");
endmodule
`default_nettype wire

// [core/jfs_comma_inserter.sv]
// end-of-frame comma character substitution on the 8B/10B byte stream
`timescale 1ns/1ps
`default_nettype none
module jfs_comma_inserter
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       clkEn,
  input  wire logic [1:0] commaSel,
  input  wire logic       mode8b10b,
  input  wire logic       frameEnd,
  input  wire logic       substOk,
  input  wire logic [7:0] dataIn,
  input  wire logic       ctrlIn,
  output logic [7:0]      dataOut_r,
  output logic            ctrlOut_r
);
  // ----------------------------------------------------------------
  // character choice
  // ----------------------------------------------------------------
  // maps comma select code to a control byte; reserved falls back to default
  function automatic logic [7:0] commaChar(input logic [1:0] sel);
    case (sel)
      jfs_pkg::COMMA_K28_1: commaChar = jfs_pkg::K28_1;
      jfs_pkg::COMMA_K28_5: commaChar = jfs_pkg::K28_5;
      default:              commaChar = jfs_pkg::K28_7;
    endcase
  endfunction

  logic [7:0] chosenChar; // selected comma character
  logic       doSubst;    // substitute this byte
  assign chosenChar = commaChar(commaSel);
  assign doSubst    = mode8b10b & frameEnd & substOk & ~ctrlIn;

  // registered byte output
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      dataOut_r <= jfs_pkg::RST_ZERO;
      ctrlOut_r <= 1'b0;
    end
    else if (clkEn)
    begin
      dataOut_r <= doSubst ? chosenChar : dataIn;
      ctrlOut_r <= doSubst | ctrlIn;
    end
  end

  a_no_subst_64b: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && !mode8b10b |=> dataOut_r == $past(dataIn) && ctrlOut_r == $past(ctrlIn))
    else $error("substitution occurred outside 8B/10B mode");
  a_subst_char: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && doSubst && commaSel == jfs_pkg::COMMA_K28_5 |=> dataOut_r == jfs_pkg::K28_5 && ctrlOut_r)
    else $error("wrong comma character inserted");
  a_opportunistic: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && !substOk && !ctrlIn |=> !ctrlOut_r && dataOut_r == $past(dataIn))
    else $error("substitution without permission");
  c_subst_k28_7: cover property (@(posedge clock) clkEn && doSubst && commaSel == jfs_pkg::COMMA_K28_7);
endmodule
`default_nettype wire

// [dv/jfs_rx_model.sv]
// receiver stand-in on the serial side: drives the SYNC~ request
`timescale 1ns/1ps
`default_nettype none
module jfs_rx_model
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic resync,
  input  wire logic ctrlSeen,
  output logic      syncReqN
);
  // request held after reset or resync, dropped once a control character arrives
  always_ff @(posedge clock)
  begin
    if (sys_rst || resync)
      syncReqN <= 1'b0;
    else if (ctrlSeen)
      syncReqN <= 1'b1;
  end
endmodule
`default_nettype wire

// [dv/jfs_link_status_regs_bench.sv]
// self-checking bench for the link frame character and status registers
`timescale 1ns/1ps
`default_nettype none
module jfs_link_status_regs_bench;
  logic        clock = 1'b0;                    // 25 MHz
  logic        sys_rst = 1'b1;                  // sync reset
  logic [11:0] regAddr = '0;                    // register port
  logic [7:0]  regWdata = '0, regRdata_r, v;    // data and scratch
  logic        regWr = 1'b0, regRd = 1'b0;      // strobes
  logic        linkUp = 1'b0, syncReqN, resync = 1'b0;
  logic        sysrefEvt = 1'b0, sysrefPhaseShift = 1'b0;
  logic        serdesPllLock = 1'b0, convPllLock = 1'b0;
  logic        frameEnd = 1'b0, substOk = 1'b0, txCtrl = 1'b0;
  logic [7:0]  txData = '0, txDataOut_r, channelPairEnable;
  logic        txCtrlOut_r, serialLinkEnable, irq;
  logic        clkEn = 1'b1;                    // clock enable
  logic [31:0] r;                               // random word
  int          bad_count = 0, compares = 0;
  // clock generator
  always #20 clock = ~clock;
  jfs_link_status_regs dut
  (
    .clock(clock), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r), .linkUp(linkUp), .syncReqN(syncReqN),
    .sysrefEvt(sysrefEvt), .sysrefPhaseShift(sysrefPhaseShift), .serdesPllLock(serdesPllLock),
    .convPllLock(convPllLock), .frameEnd(frameEnd), .substOk(substOk), .txData(txData),
    .txCtrl(txCtrl), .txDataOut_r(txDataOut_r), .txCtrlOut_r(txCtrlOut_r),
    .serialLinkEnable(serialLinkEnable), .channelPairEnable(channelPairEnable), .irq(irq)
  );
  // far-side receiver releases sync once a control character is seen
  jfs_rx_model rx
  (
    .clock(clock), .sys_rst(sys_rst), .resync(resync), .ctrlSeen(txCtrlOut_r), .syncReqN(syncReqN)
  );
  // compare one value and count it
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    #1;
  endtask
  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    d = regRdata_r;
  endtask
  // send one byte and check it one cycle later
  task automatic sendb(input logic fe, ok, c, input logic [7:0] d, ed, input logic ec);
    @(posedge clock);
    frameEnd <= fe;
    substOk <= ok;
    txCtrl <= c;
    txData <= d;
    @(posedge clock);
    #1;
    chk(txDataOut_r, ed);
    chk({7'h00, txCtrlOut_r}, {7'h00, ec});
  endtask
  // one SYSREF pulse
  task automatic sref(input logic ps);
    @(posedge clock);
    sysrefEvt <= 1'b1;
    sysrefPhaseShift <= ps;
    @(posedge clock);
    sysrefEvt <= 1'b0;
  endtask
  // expected end-of-frame character for a select code
  function automatic logic [7:0] exp_comma(input logic [1:0] c);
    case (c)
      2'h1: return jfs_pkg::K28_1;
      2'h2: return jfs_pkg::K28_5;
      default: return jfs_pkg::K28_7;
    endcase
  endfunction
  // final report and end of run
  task automatic stop_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    stop_test();
  end
  // main sequence
  initial
  begin
    logic [11:0] adr [6];
    logic [7:0]  rv [6];
    adr = '{jfs_pkg::ADDR_COMMA_SEL, jfs_pkg::ADDR_STATUS, jfs_pkg::ADDR_CHAN_EN,
            jfs_pkg::ADDR_IRQ_MASK, jfs_pkg::ADDR_LINK_CTRL, 12'h210};
    rv = '{jfs_pkg::RST_COMMA_SEL, 8'h00, jfs_pkg::RST_CHAN_EN, 8'h00, 8'h00, 8'h00};
    void'($urandom(1));
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    // reset values, unmapped address reads zero
    for (int i = 0; i < 6; i++)
    begin
      rd(adr[i], v);
      chk(v, rv[i]);
    end
    chk(channelPairEnable, jfs_pkg::RST_CHAN_EN);
    chk({7'h00, irq}, 8'h00);
    // channel enable keeps only its defined bits
    r = $urandom();
    wr(jfs_pkg::ADDR_CHAN_EN, r[7:0]);
    rd(jfs_pkg::ADDR_CHAN_EN, v);
    chk(v, r[7:0] & jfs_pkg::CHAN_EN_MASK);
    chk(channelPairEnable, r[7:0] & jfs_pkg::CHAN_EN_MASK);
    $display("test reset done");
    // comma codes in 8B/10B mode with the link disabled
    wr(jfs_pkg::ADDR_LINK_CTRL, 8'h02);
    for (int c = 0; c < 4; c++)
    begin
      r = $urandom();
      wr(jfs_pkg::ADDR_COMMA_SEL, {6'h00, c[1:0]});
      rd(jfs_pkg::ADDR_COMMA_SEL, v);
      chk(v, {6'h00, c[1:0]});
      sendb(1'b1, 1'b1, 1'b0, r[7:0], exp_comma(c[1:0]), 1'b1);
      sendb(1'b1, 1'b0, 1'b0, r[7:0], r[7:0], 1'b0);
      sendb(1'b0, 1'b1, 1'b0, r[7:0], r[7:0], 1'b0);
      sendb(1'b1, 1'b1, 1'b1, r[7:0], r[7:0], 1'b1);
      wr(jfs_pkg::ADDR_LINK_CTRL, 8'h00);
      sendb(1'b1, 1'b1, 1'b0, r[15:8], r[15:8], 1'b0);
      wr(jfs_pkg::ADDR_LINK_CTRL, 8'h02);
    end
    wr(jfs_pkg::ADDR_COMMA_SEL, 8'h00);
    $display("test comma done");
    // live status bits under random inputs, status writes ignored
    for (int i = 0; i < 24; i++)
    begin
      r = $urandom();
      @(posedge clock);
      linkUp <= r[0];
      serdesPllLock <= r[1];
      convPllLock <= r[2];
      resync <= r[12];
      @(posedge clock);
      resync <= 1'b0;
      sendb(1'b0, 1'b0, r[3], r[11:4], r[11:4], r[3]);
      wr(jfs_pkg::ADDR_STATUS, 8'hFF);
      rd(jfs_pkg::ADDR_STATUS, v);
      chk(v, {1'b0, linkUp, syncReqN, 2'b00, serdesPllLock, 1'b0, convPllLock});
    end
    $display("test live status done");
    // sticky alignment flags and interrupt
    wr(jfs_pkg::ADDR_LINK_CTRL, 8'h03);
    chk({7'h00, serialLinkEnable}, 8'h01);
    sref(1'b0);
    rd(jfs_pkg::ADDR_STATUS, v);
    chk(v & jfs_pkg::STICKY_MASK, 8'h08);
    chk({7'h00, irq}, 8'h00);
    sref(1'b1);
    rd(jfs_pkg::ADDR_STATUS, v);
    chk(v & jfs_pkg::STICKY_MASK, 8'h18);
    wr(jfs_pkg::ADDR_IRQ_MASK, 8'h18);
    chk({7'h00, irq}, 8'h01);
    wr(jfs_pkg::ADDR_IRQ_MASK, 8'h10);
    wr(jfs_pkg::ADDR_STATUS, 8'h08);
    rd(jfs_pkg::ADDR_STATUS, v);
    chk(v & jfs_pkg::STICKY_MASK, 8'h10);
    chk({7'h00, irq}, 8'h01);
    wr(jfs_pkg::ADDR_STATUS, 8'h10);
    sref(1'b0);
    rd(jfs_pkg::ADDR_STATUS, v);
    chk(v & jfs_pkg::STICKY_MASK, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(jfs_pkg::ADDR_LINK_CTRL, 8'h00);
    wr(jfs_pkg::ADDR_LINK_CTRL, 8'h03);
    sref(1'b0);
    rd(jfs_pkg::ADDR_STATUS, v);
    chk(v & jfs_pkg::STICKY_MASK, 8'h08);
    $display("test sticky done");
    // clock enable low freezes writes and flag updates
    @(posedge clock);
    clkEn <= 1'b0;
    sref(1'b1);
    wr(jfs_pkg::ADDR_STATUS, 8'h08);
    wr(jfs_pkg::ADDR_LINK_CTRL, 8'h00);
    @(posedge clock);
    clkEn <= 1'b1;
    rd(jfs_pkg::ADDR_STATUS, v);
    chk(v & jfs_pkg::STICKY_MASK, 8'h08);
    chk({7'h00, serialLinkEnable}, 8'h01);
    $display("test freeze done");
    stop_test();
  end
endmodule
`default_nettype wire
